// ===== hdl/mqp_lbus_if.sv
// carrier between the queue front end and the local-bus master
`timescale 1ns/1ps
interface mqp_lbus_if;
  logic req; // transfer request, held until ack
  logic we; // 1 write, 0 read
  logic [31:0] addr; // local byte address
  logic [31:0] wdata; // write data
  logic ack; // one-cycle completion
  logic [31:0] rdata; // read data, valid with ack
  modport front (output req, output we, output addr, output wdata, input ack, input rdata);
  modport master (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// ===== hdl/mqp_lbus_master.sv
// local-bus master: one word transfer per request
`timescale 1ns/1ps
module mqp_lbus_master (
  input wire logic core_clk_i,
  input wire logic rst_i,
  mqp_lbus_if.master lb,
  output logic lb_req_o,
  output logic lb_we_o,
  output logic [31:0] lb_addr_o,
  output logic [31:0] lb_wdata_o,
  input wire logic lb_ack_i,
  input wire logic [31:0] lb_rdata_i
);
  logic busy_reg; // a transfer is outstanding on the pins
  logic ack_s1_reg; // first synchroniser stage of the pin ack
  logic ack_s2_reg; // second stage, the only one logic reads
  logic ack_prev_reg; // for edge detection of the synchronised ack
  logic [31:0] rd_s1_reg; // read data captured alongside
  logic [31:0] rd_reg;

  // synchronise the ack pin; data is sampled two deep as well to stay aligned
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
      rd_s1_reg <= 32'h00000000;
      rd_reg <= 32'h00000000;
    end else begin
      ack_s1_reg <= lb_ack_i;
      ack_s2_reg <= ack_s1_reg;
      ack_prev_reg <= ack_s2_reg;
      rd_s1_reg <= lb_rdata_i;
      rd_reg <= rd_s1_reg;
    end
  end

  wire ack_rise = ack_s2_reg & ~ack_prev_reg; // completion event

  // drive pins from registers; hold until ack rises
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      lb_req_o <= 1'b0;
      lb_we_o <= 1'b0;
      lb_addr_o <= 32'h00000000;
      lb_wdata_o <= 32'h00000000;
    end else if (!busy_reg && lb.req && !lb.ack) begin
      busy_reg <= 1'b1;
      lb_req_o <= 1'b1;
      lb_we_o <= lb.we;
      lb_addr_o <= lb.addr;
      lb_wdata_o <= lb.wdata;
    end else if (busy_reg && ack_rise) begin
      busy_reg <= 1'b0;
      lb_req_o <= 1'b0;
    end
  end

  assign lb.ack = busy_reg & ack_rise; // handshake may be combinational
  assign lb.rdata = rd_reg;
endmodule

// ===== hdl/mqp_pkg.sv
// constants and types shared by the message queue port block
package mqp_pkg;
  localparam logic [11:0] MQP_OFS_PENDING = 12'h030; // outbound_post_pending_status
  localparam logic [11:0] MQP_OFS_MASK = 12'h034; // outbound_post_irq_mask
  localparam logic [11:0] MQP_OFS_INQ = 12'h040; // inbound_queue_port
  localparam logic [11:0] MQP_OFS_OUTQ = 12'h044; // outbound_queue_port
  localparam logic [11:0] MQP_OFS_PTR_BASE = 12'h050; // eight list pointers, one word each
  localparam int MQP_PENDING_BIT = 3; // outbound_post_pending position
  localparam int MQP_MASK_BIT = 3; // outbound_post_irq_mask_bit position
  localparam logic MQP_MASK_RESET = 1'b1; // mask reads 1 after reset
  localparam logic [31:0] MQP_EMPTY_WORD = 32'hFFFFFFFF; // answer for an empty free list
  localparam logic [31:0] MQP_ZERO_WORD = 32'h00000000; // reset value of data registers
  localparam logic [31:0] MQP_ENTRY_STEP = 32'h00000004; // byte step between list slots
  // pointer index: {queue(0 in,1 out), list(0 post,1 free), end(0 top,1 bottom)}
  localparam logic [2:0] MQP_PTR_IN_POST_TOP = 3'h0;
  localparam logic [2:0] MQP_PTR_IN_POST_BOT = 3'h1;
  localparam logic [2:0] MQP_PTR_IN_FREE_TOP = 3'h2;
  localparam logic [2:0] MQP_PTR_IN_FREE_BOT = 3'h3;
  localparam logic [2:0] MQP_PTR_OUT_POST_TOP = 3'h4;
  localparam logic [2:0] MQP_PTR_OUT_POST_BOT = 3'h5;
  localparam logic [2:0] MQP_PTR_OUT_FREE_TOP = 3'h6;
  localparam logic [2:0] MQP_PTR_OUT_FREE_BOT = 3'h7;
  // local-bus sequencer states
  typedef enum logic [3:0] {
    MQP_IDLE = 4'b0001,
    MQP_WRITE = 4'b0010,
    MQP_READ = 4'b0100,
    MQP_DONE = 4'b1000
  } mqp_state_t;
endpackage

// ===== hdl/mqp_top.sv
// message queue ports: pci-side registers backed by lists in local memory
`timescale 1ns/1ps
module mqp_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pci_sel_i, // one-cycle access strobe from the pci target
  input wire logic pci_we_i, // 1 write, 0 read
  input wire logic [11:0] pci_addr_i, // byte offset in register space
  input wire logic [31:0] pci_wdata_i,
  output logic pci_ack_o, // access completed
  output logic pci_retry_o, // access must be retried
  output logic [31:0] pci_rdata_o,
  output logic outbound_post_irq_o, // level, pending and not masked
  output logic lb_req_o,
  output logic lb_we_o,
  output logic [31:0] lb_addr_o,
  output logic [31:0] lb_wdata_o,
  input wire logic lb_ack_i,
  input wire logic [31:0] lb_rdata_i
);
  mqp_lbus_if lbi();
  mqp_pkg::mqp_state_t state_reg;
  logic [31:0] ptr_reg [8]; // list pointers, byte addresses
  logic mask_reg; // outbound_post_irq_mask_bit
  logic rd_is_out_reg; // pending read targets the outbound queue
  logic [2:0] adv_idx_reg; // pointer to advance at completion
  logic [31:0] rdata_hold_reg; // fetched entry waiting for the retried read
  logic hold_valid_reg; // fetched entry is ready
  logic hold_out_reg; // fetched entry belongs to outbound queue
  logic req_reg;
  logic we_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;

  // next slot, wrapping is left to software via the pointer registers
  function automatic logic [31:0] mqp_step(input logic [31:0] p);
    mqp_step = p + mqp_pkg::MQP_ENTRY_STEP;
  endfunction

  wire is_inq = pci_addr_i == mqp_pkg::MQP_OFS_INQ;
  wire is_outq = pci_addr_i == mqp_pkg::MQP_OFS_OUTQ;
  wire is_q = is_inq | is_outq;
  // offset into the pointer file; the file straddles a 32-byte boundary, so match by distance
  wire [11:0] ptr_ofs = pci_addr_i - mqp_pkg::MQP_OFS_PTR_BASE;
  wire is_ptr = ptr_ofs[11:5] == 7'h00 && ptr_ofs[1:0] == 2'b00;
  wire [2:0] pidx = ptr_ofs[4:2];
  wire qsel_out = is_outq;
  // a list is empty when its top equals its bottom
  wire out_post_nonempty = ptr_reg[mqp_pkg::MQP_PTR_OUT_POST_TOP] !=
                           ptr_reg[mqp_pkg::MQP_PTR_OUT_POST_BOT];
  wire free_empty_in = ptr_reg[mqp_pkg::MQP_PTR_IN_FREE_TOP] ==
                       ptr_reg[mqp_pkg::MQP_PTR_IN_FREE_BOT];
  wire free_empty_out = ptr_reg[mqp_pkg::MQP_PTR_OUT_FREE_TOP] ==
                        ptr_reg[mqp_pkg::MQP_PTR_OUT_FREE_BOT];
  wire busy = state_reg != mqp_pkg::MQP_IDLE;
  wire hold_hit = hold_valid_reg && hold_out_reg == qsel_out;
  wire q_read_empty = qsel_out ? free_empty_out : free_empty_in;
  // start a local transfer for a queue write, or a nonempty read with no entry held for that queue
  wire start = pci_sel_i && is_q && !busy && (pci_we_i || (!hold_hit && !q_read_empty));

  // queue sequencer: each local transfer ends in one done cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= mqp_pkg::MQP_IDLE;
    end else begin
      case (state_reg)
        mqp_pkg::MQP_IDLE: begin
          if (start) begin
            state_reg <= pci_we_i ? mqp_pkg::MQP_WRITE : mqp_pkg::MQP_READ;
          end
        end
        mqp_pkg::MQP_WRITE,
        mqp_pkg::MQP_READ: begin
          if (lbi.ack) begin
            state_reg <= mqp_pkg::MQP_DONE;
          end
        end
        default: begin
          state_reg <= mqp_pkg::MQP_IDLE;
        end
      endcase
    end
  end

  // local request: writes to post top, reads from free bottom
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= mqp_pkg::MQP_ZERO_WORD;
      wdata_reg <= mqp_pkg::MQP_ZERO_WORD;
      adv_idx_reg <= mqp_pkg::MQP_PTR_IN_POST_TOP;
      rd_is_out_reg <= 1'b0;
    end else if (start) begin
      req_reg <= 1'b1;
      we_reg <= pci_we_i;
      wdata_reg <= pci_wdata_i;
      rd_is_out_reg <= qsel_out;
      if (pci_we_i) begin
        adv_idx_reg <= qsel_out ? mqp_pkg::MQP_PTR_OUT_POST_TOP : mqp_pkg::MQP_PTR_IN_POST_TOP;
        addr_reg <= qsel_out ? ptr_reg[mqp_pkg::MQP_PTR_OUT_POST_TOP]
                             : ptr_reg[mqp_pkg::MQP_PTR_IN_POST_TOP];
      end else begin
        adv_idx_reg <= qsel_out ? mqp_pkg::MQP_PTR_OUT_FREE_BOT : mqp_pkg::MQP_PTR_IN_FREE_BOT;
        addr_reg <= qsel_out ? ptr_reg[mqp_pkg::MQP_PTR_OUT_FREE_BOT]
                             : ptr_reg[mqp_pkg::MQP_PTR_IN_FREE_BOT];
      end
    end else if (lbi.ack) begin
      req_reg <= 1'b0;
    end
  end

  assign lbi.req = req_reg;
  assign lbi.we = we_reg;
  assign lbi.addr = addr_reg;
  assign lbi.wdata = wdata_reg;

  // pointer file: software writes, hardware advances on completion
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        ptr_reg[i] <= mqp_pkg::MQP_ZERO_WORD;
      end
    end else if (lbi.ack) begin
      ptr_reg[adv_idx_reg] <= mqp_step(ptr_reg[adv_idx_reg]);
    end else if (pci_sel_i && pci_we_i && is_ptr) begin
      ptr_reg[pidx] <= pci_wdata_i;
    end
  end

  // a fetched entry is held until the retried read collects it or a fetch for the other queue replaces it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_valid_reg <= 1'b0;
      hold_out_reg <= 1'b0;
      rdata_hold_reg <= mqp_pkg::MQP_ZERO_WORD;
    end else if (lbi.ack && !we_reg) begin
      hold_valid_reg <= 1'b1;
      hold_out_reg <= rd_is_out_reg;
      rdata_hold_reg <= lbi.rdata;
    end else if (pci_sel_i && !pci_we_i && is_q && !busy && hold_hit) begin
      hold_valid_reg <= 1'b0;
    end
  end

  // mask bit is read-only to the pci side and sits at its reset value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_reg <= mqp_pkg::MQP_MASK_RESET;
    end else begin
      mask_reg <= mask_reg;
    end
  end

  // pci answer: queue accesses retry while a local transfer is in flight
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pci_ack_o <= 1'b0;
      pci_retry_o <= 1'b0;
      pci_rdata_o <= mqp_pkg::MQP_ZERO_WORD;
    end else begin
      pci_ack_o <= 1'b0;
      pci_retry_o <= 1'b0;
      pci_rdata_o <= mqp_pkg::MQP_ZERO_WORD;
      if (pci_sel_i) begin
        if (is_q && busy) begin
          pci_retry_o <= 1'b1;
        end else if (is_q && !pci_we_i && !hold_hit) begin
          if (q_read_empty) begin
            pci_ack_o <= 1'b1;
            pci_rdata_o <= mqp_pkg::MQP_EMPTY_WORD;
          end else begin
            pci_retry_o <= 1'b1; // fetch launched, come back for it
          end
        end else if (is_q && pci_we_i) begin
          pci_retry_o <= 1'b1;
        end else begin
          pci_ack_o <= 1'b1;
          if (!pci_we_i) begin
            if (is_q) begin
              pci_rdata_o <= rdata_hold_reg;
            end else if (pci_addr_i == mqp_pkg::MQP_OFS_PENDING) begin
              pci_rdata_o[mqp_pkg::MQP_PENDING_BIT] <= out_post_nonempty;
            end else if (pci_addr_i == mqp_pkg::MQP_OFS_MASK) begin
              pci_rdata_o[mqp_pkg::MQP_MASK_BIT] <= mask_reg;
            end else if (is_ptr) begin
              pci_rdata_o <= ptr_reg[pidx];
            end
          end
        end
      end
    end
  end

  // interrupt gated by mask; the pending flag itself is never gated
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      outbound_post_irq_o <= 1'b0;
    end else begin
      outbound_post_irq_o <= out_post_nonempty & ~mask_reg;
    end
  end

  mqp_lbus_master u_master (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .lb(lbi.master),
    .lb_req_o(lb_req_o),
    .lb_we_o(lb_we_o),
    .lb_addr_o(lb_addr_o),
    .lb_wdata_o(lb_wdata_o),
    .lb_ack_i(lb_ack_i),
    .lb_rdata_i(lb_rdata_i)
  );

  AST_WRITE_RETRY: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start && pci_we_i |=> pci_retry_o)
    else $error("queue write not answered with retry");
  AST_BUSY_RETRY: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pci_sel_i && is_q && busy |=> pci_retry_o && !pci_ack_o)
    else $error("queue access not retried while busy");
  AST_EMPTY_ONES: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pci_sel_i && is_inq && !pci_we_i && !busy && !hold_hit && free_empty_in
    |=> pci_ack_o && pci_rdata_o == 32'hFFFFFFFF)
    else $error("empty inbound free list did not read all ones");
  AST_EMPTY_ONES_OUT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pci_sel_i && is_outq && !pci_we_i && !busy && !hold_hit && free_empty_out
    |=> pci_ack_o && pci_rdata_o == 32'hFFFFFFFF)
    else $error("empty outbound free list did not read all ones");
  AST_MASK_ONE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mask_reg == 1'b1 |-> !outbound_post_irq_o)
    else $error("interrupt raised while masked");
  AST_PEND_READ: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pci_sel_i && !pci_we_i && pci_addr_i == 12'h030
    |=> pci_rdata_o[3] == $past(out_post_nonempty))
    else $error("pending flag does not match occupancy");
  AST_IN_POST_ADDR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start && pci_we_i && is_inq |=> addr_reg == $past(ptr_reg[0]) && wdata_reg == $past(pci_wdata_i))
    else $error("inbound post written to wrong address or data");
  AST_OUT_POST_ADDR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start && pci_we_i && is_outq |=> addr_reg == $past(ptr_reg[4]))
    else $error("outbound post written to wrong address");
  AST_FREE_ADDR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start && !pci_we_i && is_outq |=> addr_reg == $past(ptr_reg[7]) && !we_reg)
    else $error("outbound free read from wrong address");
  AST_IN_FREE_ADDR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start && !pci_we_i && is_inq |=> addr_reg == $past(ptr_reg[3]))
    else $error("inbound free read from wrong address");
  AST_ADVANCE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    lbi.ack |=> ptr_reg[$past(adv_idx_reg)] == $past(ptr_reg[adv_idx_reg]) + 32'h00000004)
    else $error("pointer not advanced after transfer");
endmodule

// ===== testbench/mqp_mem_model.sv
// behavioural local-bus memory answering the queue block's transfers
`timescale 1ns/1ps
module mqp_mem_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic lb_req_i,
  input wire logic lb_we_i,
  input wire logic [31:0] lb_addr_i,
  input wire logic [31:0] lb_wdata_i,
  output logic lb_ack_o,
  output logic [31:0] lb_rdata_o
);
  int delay = 2; // wait states before ack, set by the bench
  logic [31:0] mem [logic [31:0]]; // sparse word store, keyed by byte address
  // one transfer at a time; ack is held until the request drops
  initial begin
    lb_ack_o = 1'b0;
    lb_rdata_o = 32'h5A5A5A5A;
    forever begin
      @(posedge core_clk_i);
      if (!rst_i && lb_req_i === 1'b1) begin
        repeat (delay) @(posedge core_clk_i);
        #1;
        if (lb_we_i) begin
          mem[lb_addr_i] = lb_wdata_i;
        end else begin
          // unwritten places answer a value that never looks like an entry
          lb_rdata_o = mem.exists(lb_addr_i) ? mem[lb_addr_i] : ~lb_addr_i;
        end
        lb_ack_o = 1'b1;
        while (lb_req_i === 1'b1) @(posedge core_clk_i);
        #1;
        lb_ack_o = 1'b0;
        // released data bus: no stale value left behind
        lb_rdata_o = ~lb_rdata_o;
      end
    end
  end
endmodule

// ===== testbench/mqp_top_test.sv
// self-checking bench for the message queue ports
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module mqp_top_test;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pci_sel_i = 1'b0;
  logic pci_we_i = 1'b0;
  logic [11:0] pci_addr_i = 12'h000;
  logic [31:0] pci_wdata_i = 32'h00000000;
  logic pci_ack_o, pci_retry_o, outbound_post_irq_o, lb_req_o, lb_we_o, lb_ack_i;
  logic [31:0] pci_rdata_o, lb_addr_o, lb_wdata_o, lb_rdata_i, d;
  logic ak, rt;
  int err_total = 0;
  int n_checks = 0;
  localparam logic [11:0] INQ = mqp_pkg::MQP_OFS_INQ;
  localparam logic [11:0] OUTQ = mqp_pkg::MQP_OFS_OUTQ;
  always #5 core_clk_i = ~core_clk_i; // 100 MHz
  mqp_top i_mqp_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .pci_sel_i(pci_sel_i),
    .pci_we_i(pci_we_i), .pci_addr_i(pci_addr_i), .pci_wdata_i(pci_wdata_i),
    .pci_ack_o(pci_ack_o), .pci_retry_o(pci_retry_o), .pci_rdata_o(pci_rdata_o),
    .outbound_post_irq_o(outbound_post_irq_o), .lb_req_o(lb_req_o), .lb_we_o(lb_we_o),
    .lb_addr_o(lb_addr_o), .lb_wdata_o(lb_wdata_o), .lb_ack_i(lb_ack_i),
    .lb_rdata_i(lb_rdata_i));
  mqp_mem_model i_mqp_mem_model (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .lb_req_i(lb_req_o), .lb_we_i(lb_we_o), .lb_addr_i(lb_addr_o),
    .lb_wdata_i(lb_wdata_o), .lb_ack_o(lb_ack_i), .lb_rdata_o(lb_rdata_i));
  // byte offset of one of the eight list pointers
  function automatic logic [11:0] ptr(input logic [2:0] idx);
    return mqp_pkg::MQP_OFS_PTR_BASE + {7'h00, idx, 2'h0};
  endfunction
  // one pci attempt; the answer pulse is caught at either of the next two falling edges, one and two cycles later
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] wd);
    @(negedge core_clk_i);
    pci_sel_i = 1'b1;
    pci_we_i = we;
    pci_addr_i = a;
    pci_wdata_i = wd;
    @(negedge core_clk_i);
    pci_sel_i = 1'b0;
    ak = pci_ack_o;
    rt = pci_retry_o;
    d = pci_rdata_o;
    if (ak !== 1'b1 && rt !== 1'b1) begin
      @(negedge core_clk_i);
      ak = pci_ack_o;
      rt = pci_retry_o;
      d = pci_rdata_o;
    end
  endtask
  // queue read: keep retrying, as a pci master would, until acked with an entry or the all-ones empty answer
  task automatic qread(input logic [11:0] a);
    for (int i = 0; i < 100; i++) begin
      acc(1'b0, a, 32'h00000000);
      if (ak === 1'b1) break;
      repeat (3) @(negedge core_clk_i);
    end
  endtask
  // poll a pointer until it reaches the expected slot, at most 100 reads; the caller compares it
  task automatic wait_ptr(input logic [2:0] idx, input logic [31:0] exp);
    for (int i = 0; i < 100; i++) begin
      acc(1'b0, ptr(idx), 32'h00000000);
      if (d === exp) break;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog, far above the few hundred cycles the sequence needs
  initial begin
    #500000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_i = 1'b0;
    acc(1'b0, mqp_pkg::MQP_OFS_PENDING, 32'h00000000);
    `CHK(d, 32'h00000000)
    acc(1'b1, mqp_pkg::MQP_OFS_MASK, 32'h00000000);
    acc(1'b0, mqp_pkg::MQP_OFS_MASK, 32'h00000000);
    `CHK(d, 32'h00000008)
    acc(1'b0, 12'h0FC, 32'h00000000);
    `CHK({ak, d}, {1'b1, 32'h00000000})
    // inbound post with a slow memory, and a queue access while it is in flight
    i_mqp_mem_model.delay = 20;
    acc(1'b1, INQ, 32'hA5A51234);
    `CHK(rt, 1'b1)
    acc(1'b0, OUTQ, 32'h00000000);
    `CHK(rt, 1'b1)
    wait_ptr(3'h0, 32'h00000004);
    `CHK(d, 32'h00000004)
    `CHK(i_mqp_mem_model.mem[32'h00000000], 32'hA5A51234)
    acc(1'b0, ptr(3'h4), 32'h00000000);
    `CHK(d, 32'h00000000)
    // outbound post raises pending, mask keeps the interrupt low
    acc(1'b1, ptr(3'h4), 32'h00000100);
    acc(1'b1, ptr(3'h5), 32'h00000100);
    acc(1'b1, OUTQ, 32'h0BADF00D);
    `CHK(rt, 1'b1)
    wait_ptr(3'h4, 32'h00000104);
    `CHK(d, 32'h00000104)
    `CHK(i_mqp_mem_model.mem[32'h00000100], 32'h0BADF00D)
    acc(1'b0, mqp_pkg::MQP_OFS_PENDING, 32'h00000000);
    `CHK(d, 32'h00000008)
    `CHK(outbound_post_irq_o, 1'b0)
    acc(1'b1, ptr(3'h5), 32'h00000104);
    acc(1'b0, mqp_pkg::MQP_OFS_PENDING, 32'h00000000);
    `CHK(d, 32'h00000000)
    // empty free lists answer all ones
    qread(INQ);
    `CHK(d, mqp_pkg::MQP_EMPTY_WORD)
    qread(OUTQ);
    `CHK(d, mqp_pkg::MQP_EMPTY_WORD)
    // prompt memory: two inbound entries, then empty again; one outbound entry, then empty again
    i_mqp_mem_model.delay = 0;
    i_mqp_mem_model.mem[32'h00000200] = 32'h11112222;
    i_mqp_mem_model.mem[32'h00000204] = 32'h33334444;
    i_mqp_mem_model.mem[32'h00000300] = 32'h55556666;
    acc(1'b1, ptr(3'h2), 32'h00000208);
    acc(1'b1, ptr(3'h3), 32'h00000200);
    qread(INQ);
    `CHK(d, 32'h11112222)
    qread(INQ);
    `CHK(d, 32'h33334444)
    wait_ptr(3'h3, 32'h00000208);
    `CHK(d, 32'h00000208)
    qread(INQ);
    `CHK(d, mqp_pkg::MQP_EMPTY_WORD)
    acc(1'b1, ptr(3'h6), 32'h00000304);
    acc(1'b1, ptr(3'h7), 32'h00000300);
    qread(OUTQ);
    `CHK(d, 32'h55556666)
    qread(OUTQ);
    `CHK(d, mqp_pkg::MQP_EMPTY_WORD)
    finish_test();
  end
endmodule
